// ===== verilog/osw_pkg.sv
// Constants, register map and check-code function of the octal switch control
package osw_pkg;

  // Register byte offsets on the APB bus
  localparam logic [11:0] OFS_SW_REQ     = 12'h000;
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_INT_STATUS = 12'h008;
  localparam logic [11:0] OFS_INT_CLEAR  = 12'h00C;
  localparam logic [11:0] OFS_INT_ENABLE = 12'h010;

  // Widths
  localparam int unsigned NUM_SW   = 8;
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned NUM_INT  = 5;

  // Index of each input in the synchroniser bank
  localparam int unsigned PIN_EN   = 0;
  localparam int unsigned PIN_STB  = 1;
  localparam int unsigned PIN_CCE  = 2;
  localparam int unsigned PIN_VINT = 3;
  localparam int unsigned PIN_VL   = 4;
  localparam int unsigned PIN_FLT  = 5;
  localparam int unsigned PIN_LERR = 6;
  localparam int unsigned PIN_RDY  = 7;

  // Status register fields: bits 7:0 are the applied switch outputs
  localparam int unsigned ST_PINS_LSB = 8;
  localparam int unsigned ST_PINS_MSB = 15;

  // Check byte field on both read and write data
  localparam int unsigned CC_LSB   = 24;
  localparam int unsigned CC_MSB   = 31;
  localparam int unsigned CC_DBITS = 24;

  // Interrupt status bits
  localparam int unsigned INT_LINK  = 0;
  localparam int unsigned INT_UPD   = 1;
  localparam int unsigned INT_VINT  = 2;
  localparam int unsigned INT_ENOFF = 3;
  localparam int unsigned INT_VL    = 4;

  // Reset values
  localparam logic [7:0]  SW_REQ_RST  = 8'h00;
  localparam logic [4:0]  INT_EN_RST  = 5'h00;
  localparam logic [4:0]  INT_ST_RST  = 5'h00;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;
  localparam logic [7:0]  CC_INIT     = 8'h00;
  localparam logic [7:0]  CC_POLY     = 8'h07;

  // Check byte over 24 data bits, msb first, polynomial x^8+x^2+x+1
  function automatic logic [7:0] osw_check_code(input logic [23:0] data);
    logic [7:0] c;
    logic       fb;
    c = CC_INIT;
    for (int i = CC_DBITS - 1; i >= 0; i--) begin
      fb = c[7] ^ data[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CC_POLY;
      end
    end
    return c;
  endfunction : osw_check_code

endpackage : osw_pkg

// ===== verilog/osw_upd_if.sv
// Interface between the control top and the output update unit
`timescale 1ns/1ps
interface osw_upd_if;
  logic       en;         // Synchronised enable pin
  logic       strobe;     // Synchronised update strobe level
  logic       supply_ok;  // Logic and I/O supplies both above lockout
  logic [7:0] req;        // Programmed switch state
  logic [7:0] hs;         // Switch outputs as driven
  logic       upd_pulse;  // One cycle on a strobe rising edge
  logic       en_fall;    // One cycle when enable drops

  modport ctrl (output en, strobe, supply_ok, req,
                input  hs, upd_pulse, en_fall);
  modport unit (input  en, strobe, supply_ok, req,
                output hs, upd_pulse, en_fall);
endinterface : osw_upd_if

// ===== verilog/osw_update.sv
// Output update unit: strobed or transparent apply, enable gating
`timescale 1ns/1ps
module osw_update (
  input  wire logic pclk,
  input  wire logic presetn,
  osw_upd_if.unit   upd
);

  logic [7:0] applied_q;
  logic [7:0] applied_d;
  logic       strobe_q;
  logic       en_q;
  logic [7:0] hs_q;
  logic       upd_pulse_q;
  logic       en_fall_q;

  // Strobe high passes the request; strobe low holds the last value
  always_comb begin
    if (!upd.supply_ok) begin
      applied_d = osw_pkg::SW_REQ_RST;
    end else if (upd.strobe) begin
      applied_d = upd.req;
    end else begin
      applied_d = applied_q;
    end
  end

  // Applied state and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_q <= osw_pkg::SW_REQ_RST;
      strobe_q  <= 1'b0;
      en_q      <= 1'b0;
    end else begin
      applied_q <= applied_d;
      strobe_q  <= upd.strobe;
      en_q      <= upd.en;
    end
  end

  // All eight bits load in one edge, so channels switch together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q <= osw_pkg::SW_REQ_RST;
    end else if (!upd.en || !upd.supply_ok) begin
      hs_q <= osw_pkg::SW_REQ_RST;
    end else begin
      hs_q <= applied_d;
    end
  end

  // Event pulses for the interrupt status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_pulse_q <= 1'b0;
      en_fall_q   <= 1'b0;
    end else begin
      upd_pulse_q <= upd.strobe & ~strobe_q;
      en_fall_q   <= en_q & ~upd.en;
    end
  end

  assign upd.hs        = hs_q;
  assign upd.upd_pulse = upd_pulse_q;
  assign upd.en_fall   = en_fall_q;

endmodule : osw_update

// ===== verilog/osw_ctrl.sv
// Top of the octal switch control: pins, APB registers, status outputs
//
// Operation
// - Enable low turns all eight outputs off; high lets them run.
// - Strobe rising edge applies the programmed state to all outputs at once.
// - Strobe low holds outputs even when the request register changes.
// - Strobe high is transparent: request writes reach outputs at once.
// - Check enable on: outgoing data carry a check byte, incoming are checked.
// - Fault pin pulled low while any selected sticky interrupt status bit is pending.
// - Ready shown only with logic and I/O supplies both above lockout.
// - Logic supply loss clears registers and drives ready pin high.
// - Link error pin pulled low when a transaction error is detected.
// - Enable low forces outputs off whatever the strobe or request say.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module osw_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Control pins
  input  wire logic        enable_pin,
  input  wire logic        output_update_strobe,
  input  wire logic        check_code_enable,
  input  wire logic        vint_supply_ok,
  input  wire logic        vl_supply_ok,
  // Switch outputs, bit 0 is the first channel
  output logic      [7:0]  high_side_output,
  // Open-drain fault pin
  input  wire logic        fault_level,
  output logic             fault_drive,
  output logic             fault_oe_n,
  // Open-drain link error pin
  input  wire logic        link_error_flag_level,
  output logic             link_error_flag_drive,
  output logic             link_error_flag_oe_n,
  // Open-drain ready pin, pulled down outside, driven high when not ready
  input  wire logic        ready_level,
  output logic             ready_drive,
  output logic             ready_oe_n,
  // Level interrupt
  output logic             irq
);

  osw_upd_if upd ();

  // Synchroniser bank
  logic [7:0] pins_raw;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;

  // Registers
  logic [7:0]  sw_req_q;
  logic [4:0]  int_en_q;
  logic [4:0]  int_st_q;
  logic [4:0]  int_set;

  // Bus state
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // Decode and answer
  logic        hit_req;
  logic        hit_st;
  logic        hit_ist;
  logic        hit_iclr;
  logic        hit_ien;
  logic        mapped;
  logic        cc_bad;
  logic        req_err;
  logic [31:0] rd_word;
  logic        setup_acc;
  logic        final_acc;
  logic        wr_ok;

  // Live levels
  logic        en_s;
  logic        cce_s;
  logic        supply_ok;
  logic        vint_lost;

  // Output pin registers
  logic        fault_oe_n_q;
  logic        lerr_oe_n_q;
  logic        ready_oe_n_q;
  logic        irq_q;

  // Gather every outside level into one bank
  assign pins_raw = {ready_level, link_error_flag_level, fault_level,
                     vl_supply_ok, vint_supply_ok, check_code_enable,
                     output_update_strobe, enable_pin};

  // Two-flop synchronisers, one per pin; stage one feeds only stage two
  generate
    for (genvar g = 0; g < osw_pkg::NUM_PINS; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pins_raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  // Synchronised levels used by the logic
  assign en_s      = sync2_q[osw_pkg::PIN_EN];
  assign cce_s     = sync2_q[osw_pkg::PIN_CCE];
  assign supply_ok = sync2_q[osw_pkg::PIN_VINT] & sync2_q[osw_pkg::PIN_VL];
  assign vint_lost = ~sync2_q[osw_pkg::PIN_VINT];

  // Feed the update unit
  assign upd.en        = en_s;
  assign upd.strobe    = sync2_q[osw_pkg::PIN_STB];
  assign upd.supply_ok = supply_ok;
  assign upd.req       = sw_req_q;

  osw_update u_update (
    .pclk    (pclk),
    .presetn (presetn),
    .upd     (upd.unit)
  );

  assign high_side_output = upd.hs;

  // Address decode, shared by the read mux and the write path
  always_comb begin
    hit_req  = (paddr == osw_pkg::OFS_SW_REQ);
    hit_st   = (paddr == osw_pkg::OFS_STATUS);
    hit_ist  = (paddr == osw_pkg::OFS_INT_STATUS);
    hit_iclr = (paddr == osw_pkg::OFS_INT_CLEAR);
    hit_ien  = (paddr == osw_pkg::OFS_INT_ENABLE);
    mapped   = hit_req | hit_st | hit_ist | hit_iclr | hit_ien;
  end

  // Incoming check byte must match the data bits when checking is on
  assign cc_bad = cce_s & pwrite &
                  (pwdata[osw_pkg::CC_MSB:osw_pkg::CC_LSB] !=
                   osw_pkg::osw_check_code(
                     pwdata[osw_pkg::CC_DBITS-1:0]));
  assign req_err = ~mapped | cc_bad;

  // Read mux; clear register reads as zero
  always_comb begin
    rd_word = osw_pkg::DATA_ZERO;
    if (hit_req) begin
      rd_word[7:0] = sw_req_q;
    end else if (hit_st) begin
      rd_word[7:0] = upd.hs;
      rd_word[osw_pkg::ST_PINS_MSB:osw_pkg::ST_PINS_LSB] = sync2_q;
    end else if (hit_ist) begin
      rd_word[4:0] = int_st_q;
    end else if (hit_ien) begin
      rd_word[4:0] = int_en_q;
    end
    if (cce_s) begin
      rd_word[osw_pkg::CC_MSB:osw_pkg::CC_LSB] =
        osw_pkg::osw_check_code(
          rd_word[osw_pkg::CC_DBITS-1:0]);
    end
  end

  // First access cycle prepares the answer, second one completes it
  assign setup_acc = psel & penable & ~pready_q;
  assign final_acc = psel & penable & pready_q;
  assign wr_ok     = final_acc & pwrite & ~pslverr_q;

  // APB answer registers; one wait state keeps every output a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= osw_pkg::DATA_ZERO;
    end else if (setup_acc) begin
      pready_q  <= 1'b1;
      pslverr_q <= req_err;
      prdata_q  <= pwrite ? osw_pkg::DATA_ZERO : rd_word;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Switch request register; a VINT supply loss wipes it like a power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_req_q <= osw_pkg::SW_REQ_RST;
    end else if (vint_lost) begin
      sw_req_q <= osw_pkg::SW_REQ_RST;
    end else if (wr_ok && hit_req) begin
      sw_req_q <= pwdata[7:0];
    end
  end

  // Interrupt enable, which also selects the fault pin conditions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_q <= osw_pkg::INT_EN_RST;
    end else if (vint_lost) begin
      int_en_q <= osw_pkg::INT_EN_RST;
    end else if (wr_ok && hit_ien) begin
      int_en_q <= pwdata[4:0];
    end
  end

  // Events that set sticky status bits
  always_comb begin
    int_set = osw_pkg::INT_ST_RST;
    int_set[osw_pkg::INT_LINK]  = final_acc & pslverr_q;
    int_set[osw_pkg::INT_UPD]   = upd.upd_pulse;
    int_set[osw_pkg::INT_VINT]  = vint_lost;
    int_set[osw_pkg::INT_ENOFF] = upd.en_fall;
    int_set[osw_pkg::INT_VL]    = ~sync2_q[osw_pkg::PIN_VL];
  end

  // Sticky status: a set in the same cycle as its clear is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st_q <= osw_pkg::INT_ST_RST;
    end else if (vint_lost) begin
      int_st_q <= int_set;
    end else if (wr_ok && hit_iclr) begin
      int_st_q <= (int_st_q & ~pwdata[4:0]) | int_set;
    end else begin
      int_st_q <= int_st_q | int_set;
    end
  end

  // Fault and interrupt follow the selected sticky conditions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_oe_n_q <= 1'b1;
      irq_q        <= 1'b0;
    end else begin
      fault_oe_n_q <= ~|(int_st_q & int_en_q);
      irq_q        <= |(int_st_q & int_en_q);
    end
  end

  // Link error pin pulled low while the error bit is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lerr_oe_n_q <= 1'b1;
    end else begin
      lerr_oe_n_q <= ~int_st_q[osw_pkg::INT_LINK];
    end
  end

  // Ready pin: passive when both supplies are good, driven high otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_oe_n_q <= 1'b0;
    end else begin
      ready_oe_n_q <= supply_ok;
    end
  end

  // Open-drain pins only ever pull low; ready only ever pushes high
  assign fault_drive           = 1'b0;
  assign fault_oe_n            = fault_oe_n_q;
  assign link_error_flag_drive = 1'b0;
  assign link_error_flag_oe_n  = lerr_oe_n_q;
  assign ready_drive           = 1'b1;
  assign ready_oe_n            = ready_oe_n_q;
  assign irq                   = irq_q;

endmodule : osw_ctrl

// ===== testbench/osw_ctrl_checker.sv
// Port-level assertions for the octal switch control
`timescale 1ns/1ps
module osw_ctrl_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       enable_pin,
  input wire logic       output_update_strobe,
  input wire logic       vint_supply_ok,
  input wire logic       vl_supply_ok,
  input wire logic [7:0] high_side_output,
  input wire logic       fault_oe_n,
  input wire logic       link_error_flag_oe_n,
  input wire logic       ready_oe_n,
  input wire logic       irq
);
  // One clock domain, so clocking and reset are stated once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready held longer than one cycle");
  // Exactly one wait state after the access phase starts
  property p_pready_time;
    psel && penable && !pready |=> pready;
  endproperty
  a_pready_time: assert property (p_pready_time)
    else $error("pready not one cycle after access");
  property p_err_qual;
    pslverr |-> pready;
  endproperty
  a_err_qual: assert property (p_err_qual)
    else $error("pslverr outside a completion");
  // Sync stages plus output flop give three edges of latency
  property p_en_off;
    !enable_pin [*3] |=> high_side_output == 8'h00;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("outputs on while enable low");
  property p_hold;
    (!output_update_strobe && enable_pin && vint_supply_ok
     && vl_supply_ok) [*6] |=> $stable(high_side_output);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs moved with strobe low");
  // Four samples: pins already good at reset release need one edge more
  property p_ready_on;
    (vint_supply_ok && vl_supply_ok) [*4] |=> ready_oe_n;
  endproperty
  a_ready_on: assert property (p_ready_on)
    else $error("ready pin not released");
  property p_ready_off;
    !(vint_supply_ok && vl_supply_ok) [*4] |=> !ready_oe_n;
  endproperty
  a_ready_off: assert property (p_ready_off)
    else $error("ready pin not driven on supply loss");
  property p_fault;
    $rose(irq) |-> ##[0:1] !fault_oe_n;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault pin idle with selected event");
  property p_link;
    pready && pslverr |-> ##[1:3] !link_error_flag_oe_n;
  endproperty
  a_link: assert property (p_link)
    else $error("link error pin idle after refused access");

  // Main scenarios reached
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_off: cover property ($fell(enable_pin));
endmodule : osw_ctrl_checker

bind osw_ctrl osw_ctrl_checker i_osw_ctrl_checker (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .enable_pin,
  .output_update_strobe, .vint_supply_ok, .vl_supply_ok,
  .high_side_output, .fault_oe_n, .link_error_flag_oe_n, .ready_oe_n,
  .irq
);

// ===== testbench/osw_board.sv
// Board model: pull resistors on the three open-drain status pins
`timescale 1ns/1ps
module osw_board (
  input  wire logic f_dr,
  input  wire logic f_oe_n,
  input  wire logic l_dr,
  input  wire logic l_oe_n,
  input  wire logic r_dr,
  input  wire logic r_oe_n,
  output logic      f_lvl,
  output logic      l_lvl,
  output logic      r_lvl
);
  // Pull-ups give the idle high level while the device lets go
  assign f_lvl = f_oe_n ? 1'h1 : f_dr;
  assign l_lvl = l_oe_n ? 1'h1 : l_dr;
  // Pull-down outside, so a passive pin reads as ready
  assign r_lvl = r_oe_n ? 1'h0 : r_dr;
endmodule : osw_board

// ===== testbench/tb_top.sv
// Self-checking bench for the octal switch control
`timescale 1ns/1ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        enable_pin, output_update_strobe, check_code_enable;
  logic        vint_supply_ok, vl_supply_ok, irq, er;
  logic [7:0]  high_side_output;
  logic        fault_level, fault_drive, fault_oe_n;
  logic        link_error_flag_level, link_error_flag_drive;
  logic        link_error_flag_oe_n, ready_level, ready_drive, ready_oe_n;
  int          fail_count, compares;

  osw_ctrl i_osw_ctrl (.*);
  osw_board i_osw_board (
    .f_dr(fault_drive), .f_oe_n(fault_oe_n), .l_dr(link_error_flag_drive),
    .l_oe_n(link_error_flag_oe_n), .r_dr(ready_drive),
    .r_oe_n(ready_oe_n), .f_lvl(fault_level),
    .l_lvl(link_error_flag_level), .r_lvl(ready_level));

  // Clock at 10 MHz
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  // Own check byte, kept apart from the design's code
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'h0} ^ 8'h07) : {c[6:0], 1'h0};
    end
    return c;
  endfunction : crc8

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    // A slave that never answers ends the run through the common verdict
    if (n >= 20) begin
      fail_count++;
      $display("mismatch at %0t: no pready", $time);
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic t_reset;
    chk(high_side_output, 8'h00);
    apb(1'h0, osw_pkg::OFS_SW_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'h0, osw_pkg::OFS_INT_ENABLE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'h1, osw_pkg::OFS_INT_CLEAR, 32'h0000_001F);
    apb(1'h0, osw_pkg::OFS_INT_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'h0, osw_pkg::OFS_INT_CLEAR, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_transparent;
    output_update_strobe <= 1'h1;
    wt(4);
    apb(1'h1, osw_pkg::OFS_SW_REQ, 32'h0000_005A);
    wt(2);
    chk(high_side_output, 8'h5A);
    apb(1'h0, osw_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_7B5A);
    $display("test transparent done");
  endtask : t_transparent

  task automatic t_strobe;
    output_update_strobe <= 1'h0;
    wt(4);
    apb(1'h1, osw_pkg::OFS_SW_REQ, 32'h0000_00C3);
    // Drop the edge event left by the transparent test first
    apb(1'h1, osw_pkg::OFS_INT_CLEAR, 32'h0000_0002);
    apb(1'h1, osw_pkg::OFS_INT_ENABLE, 32'h0000_0002);
    wt(4);
    chk(irq, 1'h0);
    chk(high_side_output, 8'h5A);
    output_update_strobe <= 1'h1;
    wt(6);
    chk(high_side_output, 8'hC3);
    chk(irq, 1'h1);
    chk(fault_level, 1'h0);
    apb(1'h1, osw_pkg::OFS_INT_CLEAR, 32'h0000_0002);
    apb(1'h1, osw_pkg::OFS_INT_ENABLE, 32'h0000_0000);
    wt(3);
    chk(irq, 1'h0);
    chk(fault_level, 1'h1);
    // Masked event stays in status but raises nothing
    output_update_strobe <= 1'h0;
    wt(4);
    output_update_strobe <= 1'h1;
    wt(6);
    chk(irq, 1'h0);
    apb(1'h0, osw_pkg::OFS_INT_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    $display("test strobe done");
  endtask : t_strobe

  task automatic t_enable;
    enable_pin <= 1'h0;
    wt(5);
    chk(high_side_output, 8'h00);
    apb(1'h1, osw_pkg::OFS_SW_REQ, 32'h0000_00FF);
    wt(3);
    chk(high_side_output, 8'h00);
    enable_pin <= 1'h1;
    wt(5);
    apb(1'h1, osw_pkg::OFS_SW_REQ, 32'h0000_0081);
    wt(2);
    chk(high_side_output, 8'h81);
    $display("test enable done");
  endtask : t_enable

  task automatic t_error;
    apb(1'h1, 12'h100, 32'h0000_0001);
    chk(er, 1'h1);
    wt(3);
    chk(link_error_flag_level, 1'h0);
    apb(1'h1, osw_pkg::OFS_INT_CLEAR, 32'h0000_001F);
    wt(3);
    chk(link_error_flag_level, 1'h1);
    check_code_enable <= 1'h1;
    wt(4);
    apb(1'h1, osw_pkg::OFS_SW_REQ, {crc8(24'h3C) ^ 8'h01, 24'h3C});
    chk(er, 1'h1);
    apb(1'h1, osw_pkg::OFS_SW_REQ, {crc8(24'h3C), 24'h3C});
    chk(er, 1'h0);
    apb(1'h0, osw_pkg::OFS_SW_REQ, 32'h0000_0000);
    chk(rd, {crc8(24'h3C), 24'h3C});
    check_code_enable <= 1'h0;
    apb(1'h1, osw_pkg::OFS_INT_CLEAR, 32'h0000_001F);
    $display("test error done");
  endtask : t_error

  task automatic t_supply;
    vl_supply_ok <= 1'h0;
    wt(5);
    chk(ready_level, 1'h1);
    chk(high_side_output, 8'h00);
    vl_supply_ok <= 1'h1;
    wt(5);
    chk(ready_level, 1'h0);
    vint_supply_ok <= 1'h0;
    wt(5);
    chk(ready_level, 1'h1);
    vint_supply_ok <= 1'h1;
    wt(5);
    apb(1'h0, osw_pkg::OFS_SW_REQ, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test supply done");
  endtask : t_supply

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    {psel, penable, pwrite, check_code_enable} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {enable_pin, vint_supply_ok, vl_supply_ok} = 3'h7;
    output_update_strobe = 1'h0;
    presetn = 1'h0;
    wt(2);
    presetn <= 1'h1;
    wt(5);
    t_reset();
    t_transparent();
    t_strobe();
    t_enable();
    t_error();
    t_supply();
    stop_test();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #3_000_000;
    fail_count++;
    stop_test();
  end
endmodule : tb_top
